// ### include/mps_pkg.sv
// Constants, register map and carrier types of the program sequencer
package mps_pkg;
   // ==========================================================
   // Clocking
   localparam int         CLK_MHZ        = 20;
   localparam logic [4:0] CLK_MHZ_W      = 5'h14;
   localparam logic [4:0] SYS_FAST_MHZ   = 5'h0c;
   localparam logic [4:0] SYS_SLOW_MHZ   = 5'h06;
   localparam logic [1:0] PHASE_LAST     = 2'h3;
   localparam int         STARTUP_TSYS   = 1024;
   localparam logic [10:0] STARTUP_CNT   = 11'(STARTUP_TSYS - 1);
   localparam int         WDT_BASE_TRC   = 1024;
   localparam int         WDT_STEP_TRC   = 256;
   // ==========================================================
   // Program space
   localparam int          PC_W          = 11;
   localparam int          INSTR_W       = 14;
   localparam int          ROM_WORDS     = 2048;
   localparam int          STACK_DEPTH   = 4;
   localparam logic [10:0] VEC_RESET     = 11'h000;
   localparam logic [10:0] VEC_USB       = 11'h004;
   localparam logic [10:0] VEC_TIMER     = 11'h00c;
   localparam logic [10:0] PC_ONE        = 11'h001;
   localparam logic [10:0] PC_TWO        = 11'h002;
   localparam logic [2:0]  SP_FULL       = 3'h4;
   // Instruction classes, top three bits of the word
   localparam logic [2:0]  OP_JUMP       = 3'h4;
   localparam logic [2:0]  OP_CALL       = 3'h5;
   localparam logic [2:0]  OP_SKIP       = 3'h6;
   localparam logic [2:0]  OP_SYS        = 3'h7;
   localparam logic [1:0]  SYS_RET       = 2'h0;
   localparam logic [1:0]  SYS_RETI      = 2'h1;
   localparam logic [1:0]  SYS_HALT      = 2'h2;
   // ==========================================================
   // Register indexes, byte address is four times the index
   localparam logic [4:0] IDX_CTRL       = 5'h00;
   localparam logic [4:0] IDX_STATE      = 5'h01;
   localparam logic [4:0] IDX_IRQ_STAT   = 5'h02;
   localparam logic [4:0] IDX_IRQ_MASK   = 5'h03;
   localparam logic [4:0] IDX_ROM_ADDR   = 5'h04;
   localparam logic [4:0] IDX_ROM_DATA   = 5'h05;
   localparam logic [4:0] IDX_PCL        = 5'h06;
   localparam logic [4:0] IDX_WATCHDOG_SCALE       = 5'h09;
   // Control fields
   localparam int         CTRL_CLKSEL    = 0;
   localparam int         CTRL_GIE       = 1;
   localparam int         CTRL_USB_EN    = 2;
   localparam int         CTRL_TMR_EN    = 3;
   localparam int         CTRL_WDT_EN    = 4;
   localparam int         CTRL_WDT_CLR   = 5;
   localparam logic [5:0] CTRL_RESET     = 6'h01;
   // Event bits
   localparam int         EV_WDT         = 0;
   localparam int         EV_OVERFLOW    = 1;
   localparam int         EV_WAKE        = 2;
   localparam logic [2:0] EV_NONE        = 3'h0;
   localparam logic [7:0] WATCHDOG_SCALE_RESET     = 8'h00;
   // ==========================================================
   // Carriers
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } mps_wb_req_type;

   typedef enum logic [1:0] {
      ST_RUN   = 2'b00,
      ST_HALT  = 2'b01,
      ST_START = 2'b10
   } mps_state_type;
endpackage

// ### core/mps_sequencer.sv
// Program sequencer of a small microcontroller core with a Wishbone register slave
`timescale 1ns/10ps
// How it works
// RQ1: System clock runs at 6 or 12 MHz by select bit; 12 MHz after reset.
// RQ2: Four phases per instruction cycle, each phase one system clock.
// RQ3: Next instruction is fetched while the current one executes.
// RQ4: Instructions that change the counter take two cycles with a dummy cycle.
// RQ5: Counter advances by one after each fetch.
// RQ6: True skip discards the fetched instruction and continues at counter plus two.
// RQ7: Writing the low counter byte jumps inside the current 256-word page.
// RQ8: Reset clears the counter and starts execution at address zero.
// RQ9: Pending enabled USB interrupt with room on the stack vectors to 004H.
// RQ10: Pending enabled timer interrupt with room on the stack vectors to 00CH.
// RQ11: Jump and call load eleven bits from the code; return loads the stack top.
// RQ12: Program memory of 2048 words of 14 bits, read by counter or table pointer.
// RQ13: Wake from halt waits 1024 system clocks before executing.
// RQ14: Base watchdog time-out is 1024 watchdog clock periods.
// RQ15: Normal time-out is 256 times the scale value plus the base time-out.
// RQ16: Four-entry return stack; calls and interrupts push, returns pop.
// RQ17: With the stack full an interrupt stays flagged until a return frees a level.
// RQ18: Interrupt pushes the unexecuted address, loads the vector, takes two cycles.
module mps_sequencer
   import mps_pkg::*;
(
   input  wire logic                    clk,         // Input clock, 20 MHz
   input  wire logic                    rstn,        // Synchronous reset, active low
   input  wire mps_pkg::mps_wb_req_type wb_req,      // Wishbone request
   output logic                         wb_ack_o,    // Wishbone acknowledge
   output logic [31:0]                  wb_dat_o,    // Wishbone read data
   output logic                         irq_o,       // Level interrupt
   input  wire logic                    usb_event,   // USB interrupt request pulse
   input  wire logic                    timer_event, // Timer overflow pulse
   input  wire logic                    skip_cond,   // Skip condition of executing word
   input  wire logic                    wake,        // Wake-up request while halted
   input  wire logic                    rc_tick,     // Watchdog RC clock tick
   output logic [13:0]                  exec_instr,  // Instruction in execute
   output logic                         exec_valid,  // Pulse: exec_instr executes now
   output logic                         halted       // Core halted or starting up
);
   import mps_pkg::*;

   // ==========================================================
   // Registers
   logic [5:0]          ctrl_reg;
   logic [2:0]          irq_stat_reg;
   logic [2:0]          irq_mask_reg;
   logic [7:0]          watchdog_scale_reg;
   logic [PC_W-1:0]     rom_addr_reg;
   logic [INSTR_W-1:0]  rom [ROM_WORDS];
   logic [PC_W-1:0]     pc_reg;
   logic [INSTR_W-1:0]  ir_reg;
   logic                flush_reg;
   logic [PC_W-1:0]     stack_reg [STACK_DEPTH];
   logic [2:0]          sp_reg;
   logic                usb_pend_reg;
   logic                tmr_pend_reg;
   logic                pcl_req_reg;
   logic [7:0]          pcl_data_reg;
   logic [4:0]          acc_reg;
   logic [1:0]          phase_reg;
   mps_state_type       state_reg;
   logic [10:0]         start_cnt_reg;
   logic [16:0]         wdt_cnt_reg;

   // ==========================================================
   // Wishbone decode
   wire        wb_hit    = wb_req.cyc & wb_req.stb & ~wb_ack_o;
   wire        wb_wr     = wb_hit & wb_req.we & wb_req.sel[0];
   wire [4:0]  wb_idx    = wb_req.adr[6:2];
   wire        wb_map    = (wb_req.adr[7] == 1'b0) && (wb_req.adr[1:0] == 2'b00);
   wire        wr_ctrl   = wb_wr && wb_map && (wb_idx == IDX_CTRL);
   wire        wr_istat  = wb_wr && wb_map && (wb_idx == IDX_IRQ_STAT);
   wire        wr_imask  = wb_wr && wb_map && (wb_idx == IDX_IRQ_MASK);
   wire        wr_raddr  = wb_wr && wb_map && (wb_idx == IDX_ROM_ADDR);
   wire        wr_rdata  = wb_wr && wb_map && (wb_idx == IDX_ROM_DATA);
   wire        wr_pcl    = wb_wr && wb_map && (wb_idx == IDX_PCL);
   wire        wr_watchdog_scale   = wb_wr && wb_map && (wb_idx == IDX_WATCHDOG_SCALE);
   wire        wr_hi     = wb_req.sel[1];

   logic [31:0] rd_data;
   always_comb begin
      rd_data = 32'h0000_0000;
      if (!wb_map) begin
         rd_data = 32'h0000_0000;
      end else if (wb_idx == IDX_CTRL) begin
         rd_data = {26'h0, ctrl_reg};
      end else if (wb_idx == IDX_STATE) begin
         rd_data = {12'h0, state_reg, phase_reg, sp_reg, tmr_pend_reg, usb_pend_reg, pc_reg};
      end else if (wb_idx == IDX_IRQ_STAT) begin
         rd_data = {29'h0, irq_stat_reg};
      end else if (wb_idx == IDX_IRQ_MASK) begin
         rd_data = {29'h0, irq_mask_reg};
      end else if (wb_idx == IDX_ROM_ADDR) begin
         rd_data = {21'h0, rom_addr_reg};
      end else if (wb_idx == IDX_ROM_DATA) begin
         rd_data = {18'h0, rom[rom_addr_reg]};                    // [RQ12]
      end else if (wb_idx == IDX_PCL) begin
         rd_data = {24'h0, pc_reg[7:0]};
      end else if (wb_idx == IDX_WATCHDOG_SCALE) begin
         rd_data = {24'h0, watchdog_scale_reg};
      end
   end

   // ==========================================================
   // System clock tick and phases
   wire [4:0] sys_rate  = ctrl_reg[CTRL_CLKSEL] ? SYS_FAST_MHZ : SYS_SLOW_MHZ;   // [RQ1]
   wire [5:0] acc_sum   = {1'b0, acc_reg} + {1'b0, sys_rate};
   wire       sys_tick  = acc_sum >= {1'b0, CLK_MHZ_W};
   wire [4:0] acc_next  = sys_tick ? 5'(acc_sum - {1'b0, CLK_MHZ_W}) : acc_sum[4:0];
   wire       cyc_end   = sys_tick && (phase_reg == PHASE_LAST);              // [RQ2]

   always_ff @(posedge clk) begin
      if (!rstn) begin
         acc_reg   <= 5'h00;
         phase_reg <= 2'h0;
      end else begin
         acc_reg   <= acc_next;
         if (sys_tick) begin
            phase_reg <= phase_reg + 2'h1;                                   // [RQ2]
         end
      end
   end

   // ==========================================================
   // Sequencing decisions
   wire [2:0]  op_class  = ir_reg[13:11];
   wire [1:0]  sys_op    = ir_reg[1:0];
   wire        running   = (state_reg == ST_RUN);
   wire        stack_ok  = sp_reg != SP_FULL;
   wire        gie       = ctrl_reg[CTRL_GIE];
   wire        take_usb  = gie && ctrl_reg[CTRL_USB_EN] && usb_pend_reg && stack_ok;   // [RQ9] [RQ17]
   wire        take_tmr  = gie && ctrl_reg[CTRL_TMR_EN] && tmr_pend_reg && stack_ok;   // [RQ10] [RQ17]
   wire        take_int  = !flush_reg && !pcl_req_reg && (take_usb || take_tmr);
   wire        do_jump   = !flush_reg && (op_class == OP_JUMP);
   wire        do_call   = !flush_reg && (op_class == OP_CALL);
   wire        do_skip   = !flush_reg && (op_class == OP_SKIP) && skip_cond;
   wire        do_ret    = !flush_reg && (op_class == OP_SYS) &&
                           ((sys_op == SYS_RET) || (sys_op == SYS_RETI));
   wire        do_halt   = !flush_reg && (op_class == OP_SYS) && (sys_op == SYS_HALT);
   wire        do_push   = take_int || (!pcl_req_reg && do_call);                        // [RQ16]
   wire        do_pop    = !take_int && !pcl_req_reg && do_ret;
   wire [PC_W-1:0] pc_inc  = pc_reg + PC_ONE;                                            // [RQ5]
   wire [PC_W-1:0] pc_prev = pc_reg - PC_ONE;

   logic [PC_W-1:0] pc_next;
   logic [PC_W-1:0] push_val;
   logic            flush_next;
   always_comb begin
      pc_next    = pc_inc;                                                // [RQ3] [RQ5]
      push_val   = pc_reg;
      flush_next = 1'b0;
      if (pcl_req_reg) begin
         pc_next    = {pc_reg[10:8], pcl_data_reg};                       // [RQ7]
         flush_next = 1'b1;                                               // [RQ4]
      end else if (take_int) begin
         push_val   = pc_prev;                                            // [RQ18]
         pc_next    = take_usb ? VEC_USB : VEC_TIMER;                     // [RQ9] [RQ10]
         flush_next = 1'b1;                                               // [RQ18]
      end else if (do_jump || do_call) begin
         pc_next    = ir_reg[PC_W-1:0];                                   // [RQ11]
         flush_next = 1'b1;                                               // [RQ4]
      end else if (do_ret) begin
         pc_next    = stack_reg[0];                                       // [RQ11]
         flush_next = 1'b1;
      end else if (do_skip) begin
         pc_next    = pc_reg + PC_ONE;                                    // [RQ6]
         flush_next = 1'b1;                                               // [RQ6]
      end else if (do_halt) begin
         pc_next    = pc_reg;
         flush_next = 1'b1;
      end
   end

   wire step      = running && cyc_end;
   wire ovf_event = step && do_push && !stack_ok;

   // ==========================================================
   // Counter, pipeline and stack
   always_ff @(posedge clk) begin
      if (!rstn) begin
         pc_reg     <= VEC_RESET;                                         // [RQ8]
         ir_reg     <= 14'h0000;
         flush_reg  <= 1'b1;                                              // [RQ8]
         exec_instr <= 14'h0000;
         exec_valid <= 1'b0;
      end else begin
         exec_valid <= step && !flush_reg && !pcl_req_reg && !take_int;
         if (step) begin
            exec_instr <= ir_reg;
            // A transfer fetches the target in the dummy cycle that follows
            ir_reg     <= rom[pc_reg];                                                // [RQ3]
            pc_reg     <= pc_next;                                                    // [RQ5]
            flush_reg  <= flush_next;                                                 // [RQ4]
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         sp_reg <= 3'h0;
         for (int i = 0; i < STACK_DEPTH; i++) begin
            stack_reg[i] <= VEC_RESET;
         end
      end else if (step && do_push) begin
         stack_reg[0] <= push_val;                                        // [RQ16] [RQ18]
         for (int i = 1; i < STACK_DEPTH; i++) begin
            stack_reg[i] <= stack_reg[i-1];
         end
         if (stack_ok) begin
            sp_reg <= sp_reg + 3'h1;
         end
      end else if (step && do_pop) begin
         for (int i = 0; i < STACK_DEPTH - 1; i++) begin
            stack_reg[i] <= stack_reg[i+1];                               // [RQ16]
         end
         if (sp_reg != 3'h0) begin
            sp_reg <= sp_reg - 3'h1;                                      // [RQ17]
         end
      end
   end

   // ==========================================================
   // Interrupt flags and low counter byte requests
   always_ff @(posedge clk) begin
      if (!rstn) begin
         usb_pend_reg <= 1'b0;
         tmr_pend_reg <= 1'b0;
         pcl_req_reg  <= 1'b0;
         pcl_data_reg <= 8'h00;
      end else begin
         usb_pend_reg <= usb_event || (usb_pend_reg && !(step && take_int && take_usb));    // [RQ17]
         tmr_pend_reg <= timer_event ||
                         (tmr_pend_reg && !(step && take_int && !take_usb));                // [RQ17]
         if (wr_pcl) begin
            pcl_req_reg  <= 1'b1;                                         // [RQ7]
            pcl_data_reg <= wb_req.dat[7:0];
         end else if (step) begin
            pcl_req_reg  <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Halt and start-up timer
   always_ff @(posedge clk) begin
      if (!rstn) begin
         state_reg     <= ST_RUN;
         start_cnt_reg <= 11'h000;
         halted        <= 1'b0;
      end else begin
         case (state_reg)
            ST_RUN: begin
               if (step && do_halt && !pcl_req_reg && !take_int) begin
                  state_reg <= ST_HALT;
                  halted    <= 1'b1;
               end
            end
            ST_HALT: begin
               if (wake) begin
                  state_reg     <= ST_START;
                  start_cnt_reg <= STARTUP_CNT;                           // [RQ13]
               end
            end
            ST_START: begin
               if (sys_tick) begin
                  if (start_cnt_reg == 11'h000) begin
                     state_reg <= ST_RUN;                                 // [RQ13]
                     halted    <= 1'b0;
                  end else begin
                     start_cnt_reg <= start_cnt_reg - 11'h001;
                  end
               end
            end
            default: begin
               state_reg <= ST_RUN;
            end
         endcase
      end
   end

   // ==========================================================
   // Watchdog
   wire [16:0] wdt_limit = 17'(WDT_STEP_TRC) * {9'h000, watchdog_scale_reg} + 17'(WDT_BASE_TRC);   // [RQ14] [RQ15]
   wire        wdt_event = ctrl_reg[CTRL_WDT_EN] && rc_tick && (wdt_cnt_reg + 17'h1 >= wdt_limit);

   always_ff @(posedge clk) begin
      if (!rstn) begin
         wdt_cnt_reg <= 17'h00000;
      end else if (!ctrl_reg[CTRL_WDT_EN] || wdt_event || (wr_ctrl && wb_req.dat[CTRL_WDT_CLR])) begin
         wdt_cnt_reg <= 17'h00000;
      end else if (rc_tick) begin
         wdt_cnt_reg <= wdt_cnt_reg + 17'h1;                              // [RQ14]
      end
   end

   // ==========================================================
   // Software registers and program memory loading
   wire [2:0] ev_now  = {state_reg == ST_START && sys_tick && start_cnt_reg == 11'h000,
                         ovf_event, wdt_event};
   wire [2:0] ev_clr  = wr_istat ? wb_req.dat[2:0] : EV_NONE;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         ctrl_reg     <= CTRL_RESET;                                      // [RQ1]
         irq_stat_reg <= EV_NONE;
         irq_mask_reg <= EV_NONE;
         watchdog_scale_reg     <= WATCHDOG_SCALE_RESET;
         rom_addr_reg <= VEC_RESET;
      end else begin
         irq_stat_reg <= (irq_stat_reg & ~ev_clr) | ev_now;
         if (wr_ctrl) begin
            ctrl_reg <= {1'b0, wb_req.dat[4:0]};
         end
         if (wr_imask) begin
            irq_mask_reg <= wb_req.dat[2:0];
         end
         if (wr_watchdog_scale) begin
            watchdog_scale_reg <= wb_req.dat[7:0];                                  // [RQ15]
         end
         if (wr_raddr && wr_hi) begin
            rom_addr_reg <= wb_req.dat[PC_W-1:0];
         end else if (wr_rdata) begin
            rom_addr_reg <= rom_addr_reg + PC_ONE;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (wr_rdata && wr_hi) begin
         rom[rom_addr_reg] <= wb_req.dat[INSTR_W-1:0];                    // [RQ12]
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         irq_o    <= 1'b0;
      end else begin
         wb_ack_o <= wb_hit;
         wb_dat_o <= wb_hit ? rd_data : 32'h0000_0000;
         irq_o    <= |(irq_stat_reg & irq_mask_reg);
      end
   end
endmodule

// ### bench/mps_sequencer_monitor.sv
// Port checker of the program sequencer
`timescale 1ns/10ps
module mps_sequencer_monitor
   import mps_pkg::*;
(
   input wire logic                    clk,        // Clock
   input wire logic                    rstn,       // Reset, active low
   input wire mps_pkg::mps_wb_req_type wb_req,     // Bus request
   input wire logic                    wb_ack_o,   // Acknowledge
   input wire logic [31:0]             wb_dat_o,   // Read data
   input wire logic                    irq_o,      // Interrupt
   input wire logic                    wake,       // Wake request
   input wire logic                    exec_valid, // Execute pulse
   input wire logic                    halted      // Halt flag
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // ==========================================================
   // Cycles since the last wake request while halted
   logic [11:0] wait_reg;
   logic [11:0] wait_next;
   assign wait_next = (!halted || wake) ? 12'h000 : (wait_reg == 12'hfff) ? wait_reg : wait_reg + 12'h001;
   always_ff @(posedge clk) begin
      wait_reg <= rstn ? wait_next : 12'h000;
   end
   // ==========================================================
   // Assertions
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("acknowledge longer than one cycle");
   a_ack_answer: assert property (wb_req.cyc && wb_req.stb && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered in one cycle");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_req.cyc && wb_req.stb))
      else $error("acknowledge without request");
   a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside acknowledge");
   a_reset_quiet: assert property ($rose(rstn) |-> !wb_ack_o && !irq_o && !halted)
      else $error("outputs active after reset");
   a_first_fetch: assert property ($rose(rstn) |-> !exec_valid [*8])
      else $error("execute before pipeline filled");
   a_cycle_length: assert property (exec_valid |=> !exec_valid [*5])
      else $error("instruction cycle too short");
   a_halt_idle: assert property (halted |=> !exec_valid)
      else $error("execution while halted");
   a_startup_wait: assert property ($fell(halted) |-> wait_reg >= 12'h6a9 && wait_reg <= 12'h6c0)
      else $error("start-up wait length wrong");
   c_write: cover property (wb_ack_o && wb_req.we);
   c_wake: cover property ($fell(halted));
   c_irq: cover property ($rose(irq_o));
endmodule
bind mps_sequencer mps_sequencer_monitor u_mps_sequencer_monitor (.clk(clk), .rstn(rstn), .wb_req(wb_req),
   .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .irq_o(irq_o), .wake(wake), .exec_valid(exec_valid),
   .halted(halted));

// ### bench/test_mps_sequencer.sv
// Self-checking testbench of the program sequencer
`timescale 1ns/10ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin bad_count++; \
   $display("CHECK FAILED %s expected %0h seen %0h", n, e, a); end end
module test_mps_sequencer;
   import mps_pkg::*;
   typedef logic [13:0] mps_word_q_type[$];
   logic clk = 1'b0, rstn = 1'b0, usb_event = 1'b0, timer_event = 1'b0, skip_cond = 1'b0, wake = 1'b0;
   logic rc_tick = 1'b1;
   mps_wb_req_type wb_req = '0;
   logic           wb_ack_o, irq_o, exec_valid, halted;
   logic [31:0]    wb_dat_o, rd;
   logic [13:0]    exec_instr;
   mps_word_q_type seen;
   int             bad_count = 0, checked = 0;
   logic [13:0]    rom_img [34] = '{0: 14'h2010, 4: 14'h3801, 12: 14'h00cc, 13: 14'h3801, 16: 14'h0111,
      17: 14'h3000, 18: 14'h0122, 19: 14'h2820, 20: 14'h3802, 21: 14'h0155, 22: 14'h2016, 32: 14'h0200,
      33: 14'h3800, default: 14'h0000};
   always #25 clk = ~clk;
   mps_sequencer u_mps_sequencer (.clk(clk), .rstn(rstn), .wb_req(wb_req), .wb_ack_o(wb_ack_o),
      .wb_dat_o(wb_dat_o), .irq_o(irq_o), .usb_event(usb_event), .timer_event(timer_event),
      .skip_cond(skip_cond), .wake(wake), .rc_tick(rc_tick), .exec_instr(exec_instr),
      .exec_valid(exec_valid), .halted(halted));
   // Record executed words, leaving out the spin loop
   always @(posedge clk) if (exec_valid && exec_instr !== 14'h2016) seen.push_back(exec_instr);
   // ==========================================================
   // Tasks
   task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      wb_req <= '{1'b1, 1'b1, we, adr, 4'hf, dat};
      do @(posedge clk); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_req <= '0;
      @(posedge clk);
   endtask
   task automatic reset_dut();
      rstn <= 1'b0;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      seen.delete();
   endtask
   task automatic cmp_q(input string n, input mps_word_q_type e);
      `CHK(n, e.size(), seen.size())
      foreach (e[i]) `CHK(n, e[i], seen[i])
      seen.delete();
   endtask
   function automatic mps_word_q_type expect_run(input logic s);
      expect_run = {14'h2010, 14'h0111, 14'h3000};
      if (!s) expect_run.push_back(14'h0122);
      expect_run = {expect_run, 14'h2820, 14'h0200, 14'h3800, 14'h3802};
   endfunction
   task automatic test_done();
      $display("Counts: checked %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ==========================================================
   // Tests
   initial begin
      int w;
      int n;
      void'($urandom(32'hf279dea6));
      reset_dut();
      bus(0, 8'h00, 32'h0);
      `CHK("ctrl reset", 32'h1, rd)
      bus(1, 8'h80, 32'hffffffff);
      bus(0, 8'h80, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      bus(1, 8'h10, 32'h0);
      for (int i = 0; i < 34; i++) bus(1, 8'h14, {18'h0, rom_img[i]});
      bus(1, 8'h10, 32'h11);
      bus(0, 8'h14, 32'h0);
      `CHK("rom word", 32'h3000, rd)
      $display("Test registers done");
      skip_cond <= 1'($urandom);
      reset_dut();
      while (halted !== 1'b1) @(posedge clk);
      @(posedge clk);
      cmp_q("program run", expect_run(skip_cond));
      bus(0, 8'h04, 32'h0);
      `CHK("stack depth", 3'h0, rd[15:13])
      $display("Test program run done");
      bus(1, 8'h0c, 32'h4);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      while (halted !== 1'b0) @(posedge clk);
      repeat (2) @(posedge clk);
      `CHK("wake irq", 1'b1, irq_o)
      bus(1, 8'h0c, 32'h0);
      repeat (2) @(posedge clk);
      `CHK("masked irq", 1'b0, irq_o)
      bus(1, 8'h08, 32'h4);
      bus(0, 8'h08, 32'h0);
      `CHK("status cleared", 32'h0, rd)
      repeat (40) @(posedge clk);
      cmp_q("resume", {14'h0155});
      $display("Test wake done");
      bus(1, 8'h00, 32'h0f);
      usb_event <= 1'b1;
      @(posedge clk);
      usb_event <= 1'b0;
      repeat (60) @(posedge clk);
      cmp_q("usb vector", {14'h3801});
      timer_event <= 1'b1;
      @(posedge clk);
      timer_event <= 1'b0;
      repeat (60) @(posedge clk);
      cmp_q("timer vector", {14'h00cc, 14'h3801});
      bus(1, 8'h00, 32'h00);
      repeat (30) @(posedge clk);
      while (exec_valid !== 1'b1) @(posedge clk);
      @(posedge clk);
      n = 1;
      while (exec_valid !== 1'b1) begin
         @(posedge clk);
         n++;
      end
      `CHK("slow spin", 1'b1, n >= 26 && n <= 27)
      $display("Test interrupts done");
      bus(1, 8'h18, 32'h12);
      while (halted !== 1'b1) @(posedge clk);
      @(posedge clk);
      cmp_q("short jump", {14'h0122, 14'h2820, 14'h0200, 14'h3800, 14'h3802});
      $display("Test short jump done");
      w = $urandom_range(3, 0);
      bus(1, 8'h24, 32'(w));
      bus(1, 8'h0c, 32'h1);
      bus(1, 8'h00, 32'h31);
      n = 0;
      while (irq_o !== 1'b1) begin
         @(posedge clk);
         n++;
      end
      `CHK("wdt period", 1'b1, n >= 256 * w + 1020 && n <= 256 * w + 1028)
      bus(1, 8'h00, 32'h01);
      $display("Test watchdog done");
      test_done();
   end
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      test_done();
   end
endmodule
